// ---- tb/change_detect_event_config_tb_top.sv ----
// Self-checking bench for the event configuration block.
// Assumes DATA_W of 12 and thresholds fixed at +256 and -256.
module change_detect_event_config_tb_top import change_detect_pkg::*; ;
  timeunit 1ns;
  timeprecision 1ns;
  localparam logic [35:0] X_OUT = 36'h200000000;
  localparam logic [35:0] Y_OUT = 36'h000200000;
  logic ref_clk = 1'b0, srst = 1'b1, boot = 1'b0, osrd = 1'b0, isrd = 1'b0;
  logic dbd = 1'b0, dbz = 1'b0;
  logic [35:0] axis = 36'h0;
  logic [7:0] addr, wdata, rdata, d;
  logic wr, rd;
  event_report_t orep, irep;
  int n_fail = 0;
  int compares = 0;
  initial forever #25 ref_clk = ~ref_clk;
  host_model host (.ref_clk(ref_clk), .reg_addr(addr), .reg_wr(wr), .reg_rd(rd),
    .reg_wdata(wdata), .reg_rdata(rdata));
  change_detect_event_config #(.DATA_W(12)) dut (.ref_clk(ref_clk), .srst(srst),
    .boot_mode_pin(boot), .reg_addr(addr), .reg_wr(wr), .reg_rd(rd), .reg_wdata(wdata),
    .reg_rdata(rdata), .outside_src_rd(osrd), .inside_src_rd(isrd), .axis_data(axis),
    .upper_threshold(12'h100), .lower_threshold(12'hf00), .inside_debounce_done(dbd),
    .inside_debounce_zero(dbz), .outside_report(orep), .inside_report(irep));
  task automatic chk(input logic [7:0] seen, input logic [7:0] exp);
    compares++;
    if (seen !== exp) begin
      n_fail++;
      $display("Error at %0t: got %h expected %h", $time, seen, exp);
    end
  endtask
  task automatic close_out;
    $display("Checks %0d, errors %0d", compares, n_fail);
    if (n_fail == 0 && compares > 0) $display("Test passed");
    else $display("Test failed");
    $finish;
  endtask
  // Four edges so the strap passes its synchroniser before release
  task automatic do_reset(input logic pin);
    @(posedge ref_clk);
    boot <= pin;
    srst <= 1'b1;
    repeat (4) @(posedge ref_clk);
    srst <= 1'b0;
  endtask
  task automatic put(input logic [35:0] v);
    @(posedge ref_clk);
    axis <= v;
    @(posedge ref_clk);
    #1;
  endtask
  task automatic src_read(input logic outside);
    @(posedge ref_clk);
    if (outside) osrd <= 1'b1;
    else isrd <= 1'b1;
    @(posedge ref_clk);
    osrd <= 1'b0;
    isrd <= 1'b0;
    #1;
  endtask
  task automatic t_reset;
    do_reset(1'b1);
    host.rd(CFG_ADDR, d);
    chk(d, 8'h38);
    do_reset(1'b0);
    host.rd(CFG_ADDR, d);
    chk(d, 8'h00);
    host.wr(8'h30, 8'hff);
    host.rd(CFG_ADDR, d);
    chk(d, 8'h00);
    host.rd(8'h30, d);
    chk(d, 8'h00);
    host.wr(CFG_ADDR, 8'h3f);
    host.rd(CFG_ADDR, d);
    chk(d, 8'h3f);
  endtask
  task automatic t_outside;
    host.wr(CFG_ADDR, 8'h20);
    put(Y_OUT);
    chk(8'(orep), 8'h0);
    put(X_OUT);
    chk(8'(orep), 8'h9);
    put(36'h0);
    chk(8'(orep), 8'h0);
    host.wr(CFG_ADDR, 8'ha0);
    put(X_OUT);
    chk(8'(orep), 8'h9);
    put(36'h0);
    chk(8'(orep), 8'h9);
    src_read(1'b1);
    chk(8'(orep), 8'h0);
    put(X_OUT);
    chk(8'(orep), 8'h9);
    src_read(1'b1);
    chk(8'(orep), 8'h8);
    put(X_OUT);
    chk(8'(orep), 8'h8);
  endtask
  task automatic t_inside;
    host.wr(CFG_ADDR, 8'h44);
    put(36'h100000000);
    chk(8'(irep), 8'h0);
    put(36'h0);
    chk(8'(irep), 8'h9);
    put(X_OUT);
    chk(8'(irep), 8'h9);
    src_read(1'b0);
    chk(8'(irep), 8'h0);
    host.wr(CFG_ADDR, 8'h04);
    dbz <= 1'b1;
    put(36'h0);
    chk(8'(irep.flags), 8'h4);
    put(36'hf00000000);
    chk(8'(irep.flags), 8'h0);
    @(posedge ref_clk);
    dbz <= 1'b0;
    put(36'h0);
    chk(8'(irep.flags), 8'h0);
    // Debounce reached: flags follow only while the condition is true
    @(posedge ref_clk);
    dbd <= 1'b1;
    put(36'h0);
    chk(8'(irep), 8'h9);
    put(36'hf00000000);
    chk(8'(irep), 8'h8);
  endtask
  initial begin
    t_reset();
    t_outside();
    t_inside();
    close_out();
  end
  initial begin
    repeat (3000) @(posedge ref_clk);
    n_fail++;
    close_out();
  end
endmodule

// ---- tb/host_model.sv ----
// Host processor model driving the configuration register port.
// Assumes the register port samples strobes on the rising edge of ref_clk.
module host_model (
  // Clock
  input wire logic ref_clk,
  // Register port
  output logic [7:0] reg_addr,
  output logic reg_wr,
  output logic reg_rd,
  output logic [7:0] reg_wdata,
  input wire logic [7:0] reg_rdata
);
  timeunit 1ns;
  timeprecision 1ns;
  initial begin
    reg_addr = 8'h00;
    reg_wr = 1'b0;
    reg_rd = 1'b0;
    reg_wdata = 8'h00;
  end
  // Released data is inverted so a stale value cannot pass for a fresh one
  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    @(posedge ref_clk);
    reg_addr <= a;
    reg_wdata <= d;
    reg_wr <= 1'b1;
    @(posedge ref_clk);
    reg_wr <= 1'b0;
    reg_wdata <= ~d;
  endtask
  task automatic rd(input logic [7:0] a, output logic [7:0] d);
    @(posedge ref_clk);
    reg_addr <= a;
    reg_rd <= 1'b1;
    @(posedge ref_clk);
    reg_rd <= 1'b0;
    #1;
    d = reg_rdata;
  endtask
endmodule

// ---- verilog/change_detect_event_config.sv ----
// Event configuration register and per-axis event flag logic.
// Assumes axis data, thresholds and debounce status come from same-clock logic;
// the boot mode pin is asynchronous and is synchronised here.
// Summary of operation
// - Outside latch on: axis outside flags stick until outside source read.
// - Outside latch on: combined outside event asserts only on rising condition.
// - Outside latch off: axis outside flags track the condition live.
// - Inside latch on: axis inside flags stick until inside source read.
// - Inside latch on: combined inside event asserts only on rising condition.
// - Inside latch off: axis inside flags follow the condition, gated by debounce status.
// - Bits 5..3 include X, Y, Z in the outside test.
// - Bits 2..0 include X, Y, Z in the inside test.
// - Reset value zero, or 0x38 when boot mode pin is high.
// - Inside flag set only when strictly between lower and upper threshold.
// - Unlatched inside flags update when active and debounced, always if count zero.
module change_detect_event_config
  import change_detect_pkg::*;
#(
  parameter int DATA_W = 12
) (
  // Clock and reset
  input wire logic ref_clk,
  input wire logic srst,
  // Boot strap pin
  input wire logic boot_mode_pin,
  // Register port
  input wire logic [7:0] reg_addr,
  input wire logic reg_wr,
  input wire logic reg_rd,
  input wire logic [7:0] reg_wdata,
  output logic [7:0] reg_rdata,
  // Source register read strobes
  input wire logic outside_src_rd,
  input wire logic inside_src_rd,
  // Axis data and thresholds, signed
  input wire logic [3*DATA_W-1:0] axis_data,
  input wire logic [DATA_W-1:0] upper_threshold,
  input wire logic [DATA_W-1:0] lower_threshold,
  input wire logic inside_debounce_done,
  input wire logic inside_debounce_zero,
  // Event outputs
  output event_report_t outside_report,
  output event_report_t inside_report
);
  // Comparators are signed and sized for at most 16-bit samples
  if (DATA_W < 2 || DATA_W > 16) begin : g_width_check
    $error("DATA_W out of range");
  end

  logic boot_meta_ff, boot_sync_ff;
  event_config_t cfg_ff, nxt_cfg;
  logic [2:0] out_flags_ff, nxt_out_flags, in_flags_ff, nxt_in_flags;
  logic out_act_ff, nxt_out_act, in_act_ff, nxt_in_act;
  cond_state_t out_st_ff, nxt_out_st, in_st_ff, nxt_in_st;
  logic [7:0] rdata_ff, nxt_rdata;
  logic [2:0] raw_in, raw_out, sel_in, sel_out;
  logic cond_in, cond_out;

  function automatic logic strictly_inside(input logic [DATA_W-1:0] v,
                                           input logic [DATA_W-1:0] up,
                                           input logic [DATA_W-1:0] lo);
    strictly_inside = ($signed(v) < $signed(up)) && ($signed(v) > $signed(lo));
  endfunction

  // Axis comparison, X on bit 2
  always_comb begin
    for (int i = 0; i < 3; i++) begin
      raw_in[2-i] = strictly_inside(axis_data[(2-i)*DATA_W +: DATA_W],
                                    upper_threshold, lower_threshold);
    end
    // Outside means at or beyond either threshold, the complement of strictly inside
    raw_out = ~raw_in;
    sel_out = raw_out & cfg_ff.outside_axis_select;
    sel_in = raw_in & cfg_ff.inside_axis_select;
    cond_out = |sel_out;
    cond_in = |sel_in;
  end

  // Register access
  always_comb begin
    nxt_cfg = cfg_ff;
    nxt_rdata = rdata_ff;
    if (reg_wr && reg_addr == CFG_ADDR) begin
      nxt_cfg = event_config_t'(reg_wdata);
    end
    if (reg_rd && reg_addr == CFG_ADDR) begin
      nxt_rdata = cfg_ff;
    end else if (reg_rd) begin
      nxt_rdata = 8'h00;
    end
  end

  // Outside family
  always_comb begin
    nxt_out_flags = out_flags_ff;
    nxt_out_act = out_act_ff;
    nxt_out_st = out_st_ff;
    if (cfg_ff.outside_latch_enable) begin
      // Set wins over a read clear in the same cycle
      if (outside_src_rd) begin
        nxt_out_flags = 3'h0;
        nxt_out_act = 1'b0;
      end
      nxt_out_flags = nxt_out_flags | sel_out;
      case (out_st_ff)
        COND_IDLE: begin
          if (cond_out) begin
            nxt_out_act = 1'b1;
            nxt_out_st = COND_ARMED;
          end
        end
        COND_ARMED: begin
          if (!cond_out) nxt_out_st = COND_IDLE;
        end
        default: nxt_out_st = COND_IDLE;
      endcase
    end else begin
      nxt_out_flags = sel_out;
      nxt_out_act = cond_out;
      nxt_out_st = cond_out ? COND_ARMED : COND_IDLE;
    end
  end

  // Inside family
  always_comb begin
    nxt_in_flags = in_flags_ff;
    nxt_in_act = in_act_ff;
    nxt_in_st = in_st_ff;
    if (cfg_ff.inside_latch_enable) begin
      if (inside_src_rd) begin
        nxt_in_flags = 3'h0;
        nxt_in_act = 1'b0;
      end
      nxt_in_flags = nxt_in_flags | sel_in;
      case (in_st_ff)
        COND_IDLE: begin
          if (cond_in) begin
            nxt_in_act = 1'b1;
            nxt_in_st = COND_ARMED;
          end
        end
        COND_ARMED: begin
          if (!cond_in) nxt_in_st = COND_IDLE;
        end
        default: nxt_in_st = COND_IDLE;
      endcase
    end else begin
      nxt_in_act = cond_in;
      nxt_in_st = cond_in ? COND_ARMED : COND_IDLE;
      // Gated by debounce so flags do not chatter on a noisy edge
      if ((cond_in && inside_debounce_done) || inside_debounce_zero) begin
        nxt_in_flags = sel_in;
      end
    end
  end

  always_ff @(posedge ref_clk) begin
    boot_meta_ff <= boot_mode_pin;
    boot_sync_ff <= boot_meta_ff;
    if (srst) begin
      // Strap read from the synchronised pin; hold reset three cycles past pin settle
      cfg_ff <= boot_sync_ff ? CFG_RST_HIGH : CFG_RST_LOW;
      out_flags_ff <= 3'h0;
      in_flags_ff <= 3'h0;
      out_act_ff <= 1'b0;
      in_act_ff <= 1'b0;
      out_st_ff <= COND_IDLE;
      in_st_ff <= COND_IDLE;
      rdata_ff <= 8'h00;
    end else begin
      cfg_ff <= nxt_cfg;
      out_flags_ff <= nxt_out_flags;
      in_flags_ff <= nxt_in_flags;
      out_act_ff <= nxt_out_act;
      in_act_ff <= nxt_in_act;
      out_st_ff <= nxt_out_st;
      in_st_ff <= nxt_in_st;
      rdata_ff <= nxt_rdata;
    end
  end

  assign reg_rdata = rdata_ff;
  assign outside_report = '{flags: out_flags_ff, active: out_act_ff};
  assign inside_report = '{flags: in_flags_ff, active: in_act_ff};

  a_out_sticky: assert property (@(posedge ref_clk) disable iff (srst)
    cfg_ff.outside_latch_enable && $past(cfg_ff.outside_latch_enable) && !$past(outside_src_rd)
    |-> ((out_flags_ff & $past(out_flags_ff)) == $past(out_flags_ff)))
    else $error("Latched outside flag dropped without read");
  a_out_edge: assert property (@(posedge ref_clk) disable iff (srst)
    cfg_ff.outside_latch_enable && cond_out && out_st_ff == COND_ARMED
    && !outside_src_rd && !out_act_ff |=> !out_act_ff)
    else $error("Outside event reasserted without condition falling");
  a_out_live: assert property (@(posedge ref_clk) disable iff (srst)
    !cfg_ff.outside_latch_enable |=> out_flags_ff == $past(sel_out))
    else $error("Unlatched outside flags do not track condition");
  a_in_sticky: assert property (@(posedge ref_clk) disable iff (srst)
    cfg_ff.inside_latch_enable && $past(cfg_ff.inside_latch_enable) && !$past(inside_src_rd)
    |-> ((in_flags_ff & $past(in_flags_ff)) == $past(in_flags_ff)))
    else $error("Latched inside flag dropped without read");
  a_in_edge: assert property (@(posedge ref_clk) disable iff (srst)
    cfg_ff.inside_latch_enable && !cond_in ##1 cfg_ff.inside_latch_enable && cond_in
    |=> in_act_ff)
    else $error("Inside event missed rising condition");
  a_in_live: assert property (@(posedge ref_clk) disable iff (srst)
    !cfg_ff.inside_latch_enable && inside_debounce_zero |=> in_flags_ff == $past(sel_in))
    else $error("Unlatched inside flags do not follow condition");
  a_out_select: assert property (@(posedge ref_clk) disable iff (srst)
    (out_flags_ff & ~cfg_ff.outside_axis_select) == 3'h0 || cfg_ff.outside_latch_enable
    || $changed(cfg_ff))
    else $error("Disabled axis raised outside flag");
  a_none_enabled: assert property (@(posedge ref_clk) disable iff (srst)
    cfg_ff.inside_axis_select == 3'h0 && !cfg_ff.inside_latch_enable |=> !in_act_ff)
    else $error("Inside event with no axis enabled");
  a_reset_value: assert property (@(posedge ref_clk)
    $past(srst) && !srst |-> cfg_ff == ($past(boot_sync_ff) ? CFG_RST_HIGH : CFG_RST_LOW))
    else $error("Configuration reset value wrong");
  a_in_select: assert property (@(posedge ref_clk) disable iff (srst)
    ((in_flags_ff & ~$past(in_flags_ff)) & ~$past(cfg_ff.inside_axis_select)) == 3'h0)
    else $error("Disabled axis raised inside flag");
  a_in_window: assert property (@(posedge ref_clk) disable iff (srst)
    !cfg_ff.inside_latch_enable && inside_debounce_zero && cfg_ff.inside_axis_select[2]
    && $signed(axis_data[3*DATA_W-1 -: DATA_W]) < $signed(upper_threshold)
    && $signed(axis_data[3*DATA_W-1 -: DATA_W]) > $signed(lower_threshold)
    |=> in_flags_ff[2])
    else $error("X inside flag clear although strictly inside");
  a_in_hold: assert property (@(posedge ref_clk) disable iff (srst)
    !cfg_ff.inside_latch_enable && !inside_debounce_zero && !inside_debounce_done
    |=> $stable(in_flags_ff))
    else $error("Unlatched inside flags moved before debounce");
endmodule

// ---- verilog/change_detect_pkg.sv ----
// Package for the change detector event configuration block.
// Assumes a single 20 MHz device clock and a byte-wide register port.
package change_detect_pkg;
  localparam logic [7:0] CFG_ADDR = 8'h2f;
  localparam logic [7:0] CFG_RST_LOW = 8'h00;
  localparam logic [7:0] CFG_RST_HIGH = 8'h38;
  localparam int OUT_LATCH_BIT = 7;
  localparam int IN_LATCH_BIT = 6;
  localparam int OUT_SEL_LSB = 3;
  localparam int IN_SEL_LSB = 0;

  typedef struct packed {
    logic outside_latch_enable;
    logic inside_latch_enable;
    logic [2:0] outside_axis_select;
    logic [2:0] inside_axis_select;
  } event_config_t;

  typedef struct packed {
    logic [2:0] flags;
    logic active;
  } event_report_t;

  typedef enum logic [0:0] {
    COND_IDLE = 1'b0,
    COND_ARMED = 1'b1
  } cond_state_t;
endpackage
